// *** common/smc_pkg.sv ***
// Purpose: Shared constants and types of the servo motion command unit
// Assumes: 100 MHz ref_clk, 16-bit register words at word offsets
// Notes: Position halves are ordered high word first, for writes and reads
package smc_pkg;
   localparam int AW = 4;
   localparam int DW = 16;
   // Register offsets
   localparam logic [3:0] A_CMD = 4'h0;
   localparam logic [3:0] A_SPEED = 4'h1;
   localparam logic [3:0] A_ACCEL = 4'h2;
   localparam logic [3:0] A_TGT_HI = 4'h3;
   localparam logic [3:0] A_TGT_LO = 4'h4;
   localparam logic [3:0] A_POS_HI = 4'h5;
   localparam logic [3:0] A_POS_LO = 4'h6;
   localparam logic [3:0] A_STATUS = 4'h7;
   localparam logic [3:0] A_IRQ_STAT = 4'h8;
   localparam logic [3:0] A_IRQ_MASK = 4'h9;
   localparam logic [3:0] A_SLAVE = 4'hA;
   // Command codes written to A_CMD
   localparam logic [15:0] CMD_REL = 16'h0001;
   localparam logic [15:0] CMD_ABS = 16'h0002;
   localparam logic [15:0] CMD_HOME = 16'h0003;
   localparam logic [15:0] CMD_ZERO = 16'h0004;
   localparam logic [15:0] CMD_STOP = 16'h0005;
   localparam logic [15:0] CMD_CLR = 16'h0006;
   // Limits and reset values
   localparam logic [15:0] SPEED_MIN = 16'h000F;
   localparam logic [15:0] SPEED_MAX = 16'h0FA0;
   localparam logic [15:0] SPEED_RST = 16'h0064;
   localparam logic [15:0] ACCEL_RST = 16'h000A;
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hF7;
   localparam logic [7:0] SLAVE_RST = 8'h01;
   localparam logic [31:0] POS_HOME = 32'h0000_0000;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   // Status and interrupt bit positions
   localparam int ST_BUSY_B = 0;
   localparam int ST_ERR_B = 1;
   localparam int ST_DIR_B = 2;
   localparam int ST_ESTOP_B = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_REJ = 2;
   localparam int IRQ_BAD = 3;
   localparam int IRQ_W = 4;
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CPR = 4000;
   localparam int ACC_TICK_NS = 1_000_000;
   localparam int ACC_TICK_DEF = ACC_TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 17;
   // Step phase accumulator wraps at this many rpm-cycles per count
   localparam int ACC_W = 21;
   localparam logic [ACC_W-1:0] STEP_LIM = ACC_W'(CLK_HZ / CPR * 60);
   typedef enum logic [1:0] {S_IDLE, S_MOVE, S_ESTOP} smc_state_t;
endpackage : smc_pkg

// *** common/smc_pos_if.sv ***
// Purpose: Carrier between motion control and the position counter
// Assumes: Single ref_clk domain
// Notes: step is a one-cycle pulse
`timescale 1ns/1ns
interface smc_pos_if;
   logic step;
   logic dir;
   logic zero;
   logic [31:0] target;
   logic [31:0] pos;
   logic at_tgt;
   logic tgt_ahead;
   modport ctl (output step, output dir, output zero, output target,
                input pos, input at_tgt, input tgt_ahead);
   modport cnt (input step, input dir, input zero, input target,
                output pos, output at_tgt, output tgt_ahead);
endinterface : smc_pos_if

// *** hw/smc_pos.sv ***
// Purpose: Signed 32-bit absolute position counter and target compare
// Assumes: At most one count per cycle
// Notes: Counter wraps silently past the two's-complement extremes
`timescale 1ns/1ns
module smc_pos
   import smc_pkg::*;
(
   input logic ref_clk,
   input logic reset_n,
   smc_pos_if.cnt pif
);
   logic [31:0] pos_r;
   logic [31:0] diff;

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         pos_r <= POS_HOME;
      else if (pif.zero)
         pos_r <= POS_HOME;
      else if (pif.step)
         pos_r <= pif.dir ? pos_r + 32'h0000_0001 : pos_r - 32'h0000_0001;
   end

   // Signed distance picks the short way round
   assign diff = pif.target - pos_r;
   assign pif.pos = pos_r;
   assign pif.at_tgt = (pos_r == pif.target);
   assign pif.tgt_ahead = !diff[31];
endmodule : smc_pos

// *** hw/smc_top.sv ***
// Purpose: Motion command, speed ramp and position tracking of a servo drive
// Assumes: Serial front end decodes frames into word register accesses
// Notes: Step/direction inputs bypass the speed ramp entirely
`timescale 1ns/1ns
// Overview of operation
// - Speed accepted only within 15..4000 rpm
// - Settings steer bus moves, not step inputs
// - Unreachable speed flags error, emergency stop
// - Relative move adds signed count to position
// - Speed and acceleration change during moves
// - Motion commands ignored unless idle, except stop
// - Stop halts motion and returns idle
// - Position values travel as two words
// - Signed 32-bit absolute counter is readable
// - Set home zeroes the absolute counter
// - Absolute and home moves run to target
// - Answer only at slave address 1..247
module smc_top
   import smc_pkg::*;
#(
   parameter int ACC_TICK_CYC = ACC_TICK_DEF
)
(
   input logic ref_clk,
   input logic reset_n,
   input logic [AW-1:0] reg_addr,
   input logic [DW-1:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [DW-1:0] reg_rdata,
   input logic [7:0] frame_slave,
   input logic ext_step,
   input logic ext_dir,
   input logic speed_fault,
   output logic motor_step,
   output logic motor_dir,
   output logic estop,
   output logic irq
);
   smc_state_t state_r, state_nxt;
   logic sel, wr_ok, rd_ok, cmd_wr;
   logic go_rel, go_abs, go_home, go_zero, go_stop, go_clr;
   logic is_motion, accept, reject;
   logic spd_wr, spd_ok, slv_wr, slv_ok, bad_val, done_ev, err_ev;
   logic [15:0] speed_r, accel_r, tgt_hi_r, tgt_lo_r, cur_spd_r, ramp_nxt;
   logic [15:0] pos_lo_sh_r, rd_mux, status_w, rdata_r;
   logic [16:0] ramp_up;
   logic [7:0] slave_r;
   logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev;
   logic err_r;
   logic [31:0] delta, target_r;
   logic [ACC_W-1:0] acc_r, acc_sum;
   logic [TICK_W-1:0] tick_cnt_r;
   logic acc_tick, rate_tick, bus_step, step_now, dir_now;
   logic mstep_r, mdir_r;

   smc_pos_if pif();

   smc_pos u_pos
   (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pif(pif.cnt)
   );

   // Register access decode
   assign sel = (frame_slave == slave_r);
   assign wr_ok = reg_wr && sel;
   assign rd_ok = reg_rd && sel;
   assign cmd_wr = wr_ok && (reg_addr == A_CMD);
   assign go_rel = cmd_wr && (reg_wdata == CMD_REL);
   assign go_abs = cmd_wr && (reg_wdata == CMD_ABS);
   assign go_home = cmd_wr && (reg_wdata == CMD_HOME);
   assign go_zero = cmd_wr && (reg_wdata == CMD_ZERO);
   assign go_stop = cmd_wr && (reg_wdata == CMD_STOP);
   assign go_clr = cmd_wr && (reg_wdata == CMD_CLR);
   assign is_motion = go_rel || go_abs || go_home || go_zero;
   assign accept = is_motion && (state_r == S_IDLE);
   assign reject = is_motion && (state_r != S_IDLE);
   assign spd_wr = wr_ok && (reg_addr == A_SPEED);
   assign spd_ok = (reg_wdata >= SPEED_MIN) && (reg_wdata <= SPEED_MAX);
   assign slv_wr = wr_ok && (reg_addr == A_SLAVE);
   assign slv_ok = (reg_wdata >= {8'h00, ADDR_MIN}) && (reg_wdata <= {8'h00, ADDR_MAX});
   assign bad_val = (spd_wr && !spd_ok) || (slv_wr && !slv_ok);
   assign delta = {tgt_hi_r, tgt_lo_r};

   // Motion state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:
         begin
            if (accept && !go_zero)
               state_nxt = S_MOVE;
         end
         S_MOVE:
         begin
            if (speed_fault)
               state_nxt = S_ESTOP;
            else if (go_stop || pif.at_tgt)
               state_nxt = S_IDLE;
         end
         S_ESTOP:
         begin
            if (go_clr)
               state_nxt = S_IDLE;
         end
         default:
            state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         state_r <= S_IDLE;
      else
         state_r <= state_nxt;
   end

   assign done_ev = (state_r == S_MOVE) && !speed_fault && (go_stop || pif.at_tgt);
   assign err_ev = (state_r == S_MOVE) && speed_fault;

   // Move target, fixed at acceptance
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         target_r <= POS_HOME;
      else if (accept && go_rel)
         target_r <= pif.pos + delta;
      else if (accept && go_abs)
         target_r <= delta;
      else if (accept && go_home)
         target_r <= POS_HOME;
   end

   // Settings registers, writable at any time
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         speed_r <= SPEED_RST;
      else if (spd_wr && spd_ok)
         speed_r <= reg_wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         accel_r <= ACCEL_RST;
      else if (wr_ok && (reg_addr == A_ACCEL))
         accel_r <= reg_wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         tgt_hi_r <= WORD_ZERO;
         tgt_lo_r <= WORD_ZERO;
      end
      else
      begin
         if (wr_ok && (reg_addr == A_TGT_HI))
            tgt_hi_r <= reg_wdata;
         if (wr_ok && (reg_addr == A_TGT_LO))
            tgt_lo_r <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         slave_r <= SLAVE_RST;
      else if (slv_wr && slv_ok)
         slave_r <= reg_wdata[7:0];
   end

   // Acceleration time base
   assign acc_tick = (tick_cnt_r == TICK_W'(ACC_TICK_CYC - 1));

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n || acc_tick)
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= tick_cnt_r + 1'b1;
   end

   // Speed ramp toward the setting; a new setting bends a running ramp
   assign ramp_up = {1'b0, cur_spd_r} + {1'b0, accel_r};

   always_comb
   begin
      ramp_nxt = cur_spd_r;
      if (cur_spd_r < speed_r)
         ramp_nxt = (ramp_up > {1'b0, speed_r}) ? speed_r : ramp_up[15:0];
      else if (cur_spd_r > speed_r)
         ramp_nxt = ((cur_spd_r - speed_r) > accel_r) ? cur_spd_r - accel_r : speed_r;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n || (state_r != S_MOVE))
         cur_spd_r <= SPEED_MIN;
      else if (acc_tick)
         cur_spd_r <= ramp_nxt;
   end

   // Step rate from a phase accumulator, one count per overflow
   assign acc_sum = acc_r + ACC_W'(cur_spd_r);
   assign rate_tick = (state_r == S_MOVE) && (acc_sum >= STEP_LIM);

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n || (state_r != S_MOVE))
         acc_r <= '0;
      else if (rate_tick)
         acc_r <= acc_sum - STEP_LIM;
      else
         acc_r <= acc_sum;
   end

   // A fault or stop in the same cycle suppresses the step
   assign bus_step = rate_tick && !pif.at_tgt && !speed_fault && !go_stop;
   assign step_now = bus_step || ((state_r == S_IDLE) && ext_step);
   assign dir_now = (state_r == S_MOVE) ? pif.tgt_ahead : ext_dir;
   assign pif.step = step_now;
   assign pif.dir = dir_now;
   assign pif.zero = accept && go_zero;
   assign pif.target = target_r;

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         mstep_r <= 1'b0;
         mdir_r <= 1'b0;
      end
      else
      begin
         mstep_r <= step_now;
         mdir_r <= dir_now;
      end
   end

   // Error flag, held until cleared
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         err_r <= 1'b0;
      else if (err_ev)
         err_r <= 1'b1;
      else if (go_clr)
         err_r <= 1'b0;
   end

   // Interrupts: set wins over the clearing read
   always_comb
   begin
      irq_ev = '0;
      irq_ev[IRQ_DONE] = done_ev;
      irq_ev[IRQ_ERR] = err_ev;
      irq_ev[IRQ_REJ] = reject;
      irq_ev[IRQ_BAD] = bad_val;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         irq_stat_r <= '0;
      else if (rd_ok && (reg_addr == A_IRQ_STAT))
         irq_stat_r <= irq_ev;
      else
         irq_stat_r <= irq_stat_r | irq_ev;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         irq_mask_r <= '0;
      else if (wr_ok && (reg_addr == A_IRQ_MASK))
         irq_mask_r <= reg_wdata[IRQ_W-1:0];
   end

   // High read latches the low half so the pair is coherent
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         pos_lo_sh_r <= WORD_ZERO;
      else if (rd_ok && (reg_addr == A_POS_HI))
         pos_lo_sh_r <= pif.pos[15:0];
   end

   always_comb
   begin
      status_w = WORD_ZERO;
      status_w[ST_BUSY_B] = (state_r == S_MOVE);
      status_w[ST_ERR_B] = err_r;
      status_w[ST_DIR_B] = mdir_r;
      status_w[ST_ESTOP_B] = (state_r == S_ESTOP);
   end

   always_comb
   begin
      case (reg_addr)
         A_SPEED: rd_mux = speed_r;
         A_ACCEL: rd_mux = accel_r;
         A_TGT_HI: rd_mux = tgt_hi_r;
         A_TGT_LO: rd_mux = tgt_lo_r;
         A_POS_HI: rd_mux = pif.pos[31:16];
         A_POS_LO: rd_mux = pos_lo_sh_r;
         A_STATUS: rd_mux = status_w;
         A_IRQ_STAT: rd_mux = {{(DW-IRQ_W){1'b0}}, irq_stat_r};
         A_IRQ_MASK: rd_mux = {{(DW-IRQ_W){1'b0}}, irq_mask_r};
         A_SLAVE: rd_mux = {8'h00, slave_r};
         default: rd_mux = WORD_ZERO;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n || !rd_ok)
         rdata_r <= WORD_ZERO;
      else
         rdata_r <= rd_mux;
   end

   assign reg_rdata = rdata_r;
   assign motor_step = mstep_r;
   assign motor_dir = mdir_r;
   assign estop = (state_r == S_ESTOP);
   assign irq = |(irq_stat_r & irq_mask_r);

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   chk_speed_range: assert property (speed_r >= SPEED_MIN && speed_r <= SPEED_MAX)
      else $error("speed setting out of range");
   chk_bad_speed: assert property (spd_wr && !spd_ok |=> $stable(speed_r))
      else $error("out of range speed taken");
   chk_ext_pass: assert property (state_r == S_IDLE && ext_step |=> motor_step)
      else $error("idle step input not passed");
   chk_fault_stop: assert property (err_ev |=> estop && !motor_step ##1 !motor_step)
      else $error("fault did not stop motion");
   chk_rel_target: assert property (accept && go_rel |=>
      state_r == S_MOVE && target_r == $past(pif.pos) + $past(delta))
      else $error("relative target wrong");
   chk_live_speed: assert property (state_r == S_MOVE && spd_wr && spd_ok && !speed_fault
      |=> speed_r == $past(reg_wdata))
      else $error("speed not updated during move");
   chk_busy_reject: assert property (reject |=> $stable(target_r) && irq_stat_r[IRQ_REJ])
      else $error("busy command not ignored");
   chk_stop_idle: assert property (state_r == S_MOVE && go_stop && !speed_fault
      |=> state_r == S_IDLE && !motor_step ##1 (!motor_step || $past(ext_step)))
      else $error("stop did not return idle");
   chk_pos_count: assert property (step_now && !pif.zero |=>
      pif.pos == ($past(dir_now) ? $past(pif.pos) + 32'h0000_0001
                                 : $past(pif.pos) - 32'h0000_0001))
      else $error("position count wrong");
   chk_set_home: assert property (accept && go_zero |=> pif.pos == POS_HOME)
      else $error("set home did not zero");
   chk_at_target: assert property (state_r == S_MOVE && pif.at_tgt && !speed_fault
      |=> state_r == S_IDLE && irq_stat_r[IRQ_DONE])
      else $error("move did not end at target");
   chk_slave_sel: assert property (reg_rd && !sel |=> reg_rdata == WORD_ZERO)
      else $error("answered foreign address");
   chk_pos_order: assert property (rd_ok && reg_addr == A_POS_HI
      |=> reg_rdata == $past(pif.pos[31:16]) && pos_lo_sh_r == $past(pif.pos[15:0]))
      else $error("position halves out of order");

   cov_move_done: cover property (state_r == S_MOVE ##1 state_r == S_IDLE);
   cov_estop: cover property (err_ev ##1 estop);
   cov_reject: cover property (reject);
   cov_irq: cover property (irq);
endmodule : smc_top

// *** testbench/smc_bus_master.sv ***
// Purpose: Register bus master standing in for the serial front end
// Assumes: Single ref_clk domain, slave never stalls
// Notes: Released address and data lines show the inverse of their last value
`timescale 1ns/1ns
module smc_bus_master
   import smc_pkg::*;
(
   input logic ref_clk,
   output logic [AW-1:0] reg_addr,
   output logic [DW-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input logic [DW-1:0] reg_rdata,
   output logic [7:0] frame_slave
);
   logic [7:0] slave_id = ADDR_MIN;
   initial
   begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      frame_slave = ADDR_MIN;
   end
   // One access; strobes are never high together
   task automatic acc(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      output logic [DW-1:0] q);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      frame_slave <= slave_id;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // A stale value must not pass for a held one
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
      q = reg_rdata;
   endtask : acc
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      logic [DW-1:0] q;
      acc(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
      acc(1'b0, a, WORD_ZERO, q);
   endtask : rd
   // Signed count as two words, high word first
   task automatic wr32(input logic [31:0] v);
      wr(A_TGT_HI, v[31:16]);
      wr(A_TGT_LO, v[15:0]);
   endtask : wr32
   task automatic rd_pos(output logic [31:0] p);
      logic [DW-1:0] hi;
      logic [DW-1:0] lo;
      rd(A_POS_HI, hi);
      rd(A_POS_LO, lo);
      p = {hi, lo};
   endtask : rd_pos
endmodule : smc_bus_master

// *** testbench/smc_top_tb_top.sv ***
// Purpose: Self-checking bench of the motion command unit
// Assumes: Short ramp tick so moves finish in a few thousand cycles
// Notes: Expected positions and step counts follow from the commanded targets
`timescale 1ns/1ns
module smc_top_tb_top
   import smc_pkg::*;
();
   logic ref_clk = 1'b0;
   logic reset_n;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [DW-1:0] reg_rdata;
   logic [7:0] frame_slave;
   logic ext_step;
   logic ext_dir;
   logic speed_fault;
   logic motor_step;
   logic motor_dir;
   logic estop;
   logic irq;
   int mismatches = 0;
   int check_count = 0;
   int steps = 0;
   logic step_dir;
   logic [DW-1:0] s;
   logic [31:0] p;
   int n;
   logic [15:0] spd_in [5] = '{16'h000E, 16'h000F, 16'h0FA0, 16'h0FA1, 16'h0000};
   logic [15:0] spd_ex [5] = '{16'h0064, 16'h000F, 16'h0FA0, 16'h0FA0, 16'h0FA0};
   logic [15:0] mv_cmd [5] = '{CMD_REL, CMD_ABS, CMD_HOME, CMD_REL, CMD_ZERO};
   logic [31:0] mv_tgt [5] = '{32'hFFFF_FFFB, 32'h0000_0004, 32'h0000_0000,
                              32'h0000_0002, 32'h0000_0000};
   logic [31:0] mv_pos [5] = '{32'hFFFF_FFFE, 32'h0000_0004, 32'h0000_0000,
                              32'h0000_0002, 32'h0000_0000};
   int mv_steps [5] = '{5, 6, 4, 2, 0};
   logic mv_dir [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   smc_top #(.ACC_TICK_CYC(10)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .frame_slave(frame_slave), .ext_step(ext_step),
      .ext_dir(ext_dir), .speed_fault(speed_fault), .motor_step(motor_step),
      .motor_dir(motor_dir), .estop(estop), .irq(irq));
   smc_bus_master m_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_slave(frame_slave));
   always @(posedge ref_clk)
   begin
      if (motor_step === 1'b1)
      begin
         steps++;
         step_dir = motor_dir;
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string what);
      logic [DW-1:0] q;
      m_u.rd(a, q);
      chk({16'h0000, q}, {16'h0000, exp}, what);
   endtask : rdc
   task automatic move(input logic [15:0] cmd);
      logic [DW-1:0] q;
      steps = 0;
      m_u.wr(A_CMD, cmd);
      for (int i = 0; i < 5000; i++)
      begin
         m_u.rd(A_STATUS, q);
         if (q[ST_BUSY_B] === 1'b0)
            return;
      end
      mismatches++;
      print_verdict();
   endtask : move
   initial
   begin
      #900_000;
      mismatches++;
      print_verdict();
   end
   initial
   begin
      reset_n = 1'b0;
      ext_step = 1'b0;
      ext_dir = 1'b0;
      speed_fault = 1'b0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      rdc(A_SPEED, SPEED_RST, "speed reset");
      rdc(A_ACCEL, ACCEL_RST, "accel reset");
      rdc(A_SLAVE, {8'h00, SLAVE_RST}, "slave reset");
      rdc(A_IRQ_MASK, WORD_ZERO, "mask reset");
      rdc(A_STATUS, WORD_ZERO, "status reset");
      rdc(4'hF, WORD_ZERO, "unmapped read");
      for (int i = 0; i < 5; i++)
      begin
         m_u.wr(A_SPEED, spd_in[i]);
         rdc(A_SPEED, spd_ex[i], "speed range");
      end
      chk(irq, 1'b0, "masked irq");
      rdc(A_IRQ_STAT, 16'h0008, "bad value flag");
      rdc(A_IRQ_STAT, WORD_ZERO, "read clears");
      m_u.wr(A_SLAVE, 16'h0000);
      m_u.wr(A_SLAVE, 16'h00F8);
      rdc(A_SLAVE, 16'h0001, "slave range");
      m_u.wr(A_SLAVE, 16'h00F7);
      m_u.wr(A_SPEED, 16'h000F);
      rdc(A_SPEED, WORD_ZERO, "other slave");
      m_u.slave_id = ADDR_MAX;
      rdc(A_SPEED, 16'h0FA0, "own slave");
      rdc(A_IRQ_STAT, 16'h0008, "bad slave flag");
      // Relative move, disturbed by a refused command and a speed change
      m_u.wr(A_ACCEL, 16'h01F4);
      m_u.wr32(32'h0000_0003);
      steps = 0;
      m_u.wr(A_CMD, CMD_REL);
      m_u.wr(A_CMD, CMD_ZERO);
      m_u.rd(A_STATUS, s);
      chk(s[ST_BUSY_B], 1'b1, "busy in move");
      m_u.wr(A_SPEED, 16'h07D0);
      rdc(A_SPEED, 16'h07D0, "speed in move");
      n = steps;
      move(WORD_ZERO);
      chk(32'(n + steps), 32'h0000_0003, "rel steps");
      chk(step_dir, 1'b1, "rel dir");
      m_u.rd_pos(p);
      chk(p, 32'h0000_0003, "rel pos");
      rdc(A_IRQ_STAT, 16'h0005, "done and refused");
      // Negative relative, absolute, go home, positive relative, set home
      for (int i = 0; i < 5; i++)
      begin
         m_u.wr32(mv_tgt[i]);
         move(mv_cmd[i]);
         chk(32'(steps), 32'(mv_steps[i]), "move steps");
         chk(step_dir, mv_dir[i], "move dir");
         m_u.rd_pos(p);
         chk(p, mv_pos[i], "move pos");
      end
      // External steps bypass the slow speed setting
      m_u.wr(A_SPEED, 16'h000F);
      steps = 0;
      ext_dir <= 1'b1;
      repeat (3)
      begin
         @(posedge ref_clk);
         ext_step <= 1'b1;
         @(posedge ref_clk);
         ext_step <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      #1;
      chk(32'(steps), 32'h0000_0003, "ext steps");
      m_u.rd_pos(p);
      chk(p, 32'h0000_0003, "ext pos");
      // Stop in mid-move
      m_u.wr(A_SPEED, 16'h0FA0);
      m_u.wr32(32'h0000_03E8);
      steps = 0;
      m_u.wr(A_CMD, CMD_REL);
      repeat (3000) @(posedge ref_clk);
      m_u.wr(A_CMD, CMD_STOP);
      n = steps;
      m_u.rd(A_STATUS, s);
      chk(s[ST_BUSY_B], 1'b0, "stopped idle");
      repeat (2000) @(posedge ref_clk);
      #1;
      chk(32'(steps), 32'(n), "no steps after stop");
      m_u.rd_pos(p);
      chk(p, 32'(3 + n), "stop pos");
      // Unreachable speed
      rdc(A_IRQ_STAT, 16'h0001, "stop flags");
      m_u.wr(A_IRQ_MASK, 16'h0002);
      m_u.wr(A_CMD, CMD_REL);
      repeat (500) @(posedge ref_clk);
      speed_fault <= 1'b1;
      repeat (2) @(posedge ref_clk);
      speed_fault <= 1'b0;
      #1;
      chk(estop, 1'b1, "estop");
      n = steps;
      repeat (1000) @(posedge ref_clk);
      #1;
      chk(32'(steps), 32'(n), "halt in estop");
      chk(irq, 1'b1, "irq raised");
      m_u.rd(A_STATUS, s);
      chk(s[ST_ERR_B], 1'b1, "err flag");
      m_u.wr(A_CMD, CMD_ABS);
      m_u.rd(A_IRQ_STAT, s);
      chk(s & 16'h0006, 16'h0006, "err and refused");
      chk(irq, 1'b0, "irq cleared");
      m_u.wr(A_CMD, CMD_CLR);
      chk(estop, 1'b0, "estop cleared");
      print_verdict();
   end
endmodule : smc_top_tb_top
